// File: dv/sdd_host_model.sv
// Host side model that collects lane words on both edges of the forwarded clock.
`timescale 1ns/1ns
module sdd_host_model (
  // Lanes from the device
  input wire logic forwarded_output_clock,
  input wire logic [3:0] decoded_nibble_lanes,
  input wire logic idle_char_flag_lane,
  // Collected words
  output logic [4:0] raw_word,
  output logic [7:0] byte_word,
  output logic byte_idle,
  output int edge_count
);
  logic [3:0] hi_nib;
  initial begin
    raw_word = 5'h00;
    byte_word = 8'h00;
    byte_idle = 1'b0;
    edge_count = 0;
    hi_nib = 4'h0;
  end
  // Every edge carries one five-lane word; two of them make an eight-bit byte plus the idle flag of the falling edge.
  always @(forwarded_output_clock) begin
    raw_word = {idle_char_flag_lane, decoded_nibble_lanes};
    edge_count = edge_count + 1;
    if (forwarded_output_clock) begin
      hi_nib = decoded_nibble_lanes;
    end else begin
      byte_word = {hi_nib, decoded_nibble_lanes};
      byte_idle = idle_char_flag_lane;
    end
  end
endmodule

// File: dv/sdd_top_tb.sv
// Self-checking bench for the deserializer output control block.
`timescale 1ns/1ns
module sdd_top_tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic device_reset_n = 1'b1;
  logic stream_mode_sel = 1'b0;
  logic serial_input_select = 1'b0;
  logic cdr_phase_lost = 1'b0;
  logic serial_bit_clk = 1'b0;
  logic serial_input_a = 1'b0;
  logic serial_input_b = 1'b0;
  logic [1:0] serial_rate_a = 2'h0;
  logic [1:0] serial_rate_b = 2'h0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata, v;
  logic [3:0] lanes;
  logic flag, fclk, lock_n, loopthrough_out, output_swing_large;
  logic [6:0] bus_address;
  logic [4:0] raw_word;
  logic [7:0] byte_word;
  logic byte_idle;
  logic [19:0] pat = 20'hfffff;
  int edge_count, mismatches, checked, n, e0, full;
  initial mismatches = 0;
  initial checked = 0;

  sdd_top #(.ACQ_CYCLES(200), .RELOCK_CYCLES(100)) sdd_top_inst (.mclk(mclk), .resetn(resetn),
    .device_reset_n(device_reset_n), .stream_mode_sel(stream_mode_sel),
    .serial_input_select(serial_input_select), .cdr_phase_lost(cdr_phase_lost),
    .serial_bit_clk(serial_bit_clk), .serial_input_a(serial_input_a),
    .serial_input_b(serial_input_b), .serial_rate_a(serial_rate_a),
    .serial_rate_b(serial_rate_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .decoded_nibble_lanes(lanes),
    .idle_char_flag_lane(flag), .forwarded_output_clock(fclk), .lock_n(lock_n),
    .loopthrough_out(loopthrough_out), .output_swing_large(output_swing_large),
    .bus_address(bus_address));
  sdd_host_model sdd_host_model_inst (.forwarded_output_clock(fclk),
    .decoded_nibble_lanes(lanes), .idle_char_flag_lane(flag), .raw_word(raw_word),
    .byte_word(byte_word), .byte_idle(byte_idle), .edge_count(edge_count));

  ////////////////////////////////////////////////////////////////////////////////
  always #5 mclk = ~mclk;
  always #80 serial_bit_clk = ~serial_bit_clk;
  // Serial data changes on the falling bit clock so the rising sample is clean.
  always @(negedge serial_bit_clk) begin
    serial_input_a <= pat[19];
    pat <= {pat[18:0], pat[19]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk) #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk) #1;
    reg_addr = a;
    repeat (2) @(posedge mclk);
    #1 v = reg_rdata;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic wait_lock(input logic lvl, input int bound);
    n = 0;
    while (lock_n !== lvl) begin
      @(posedge mclk) #1;
      n++;
      if (n > bound) begin
        mismatches++;
        $display("CHECK FAILED lock_n wait expected %b seen %b", lvl, lock_n);
        report_and_stop();
      end
    end
  endtask
  // Waits until the collected byte carries the wanted idle flag.
  task automatic wait_idle(input logic lvl, input int bound);
    n = 0;
    while (byte_idle !== lvl) begin
      @(posedge mclk) #1;
      n++;
      if (n > bound) begin
        mismatches++;
        $display("CHECK FAILED idle flag wait expected %b seen %b", lvl, byte_idle);
        report_and_stop();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    #1 resetn = 1'b1;
    chk("lock_n", lock_n, 1);
    chk("bus_address", bus_address, 7'h2d);
    chk("swing", output_swing_large, 0);
    repeat (4) @(posedge mclk);
    rd(8'h27);
    chk("swing reg", v, 8'h00);
    rd(8'h28);
    chk("timing reg", v, 8'h00);
    wr(8'h27, 8'h01);
    chk("swing", output_swing_large, 1);
    rd(8'h27);
    chk("swing reg", v, 8'h01);
    wr(8'h00, 8'h15);
    rd(8'h33);
    chk("unmapped", v, 8'h00);
    wr(8'h01, 8'h00);
    chk("swing", output_swing_large, 0);
    chk("bus_address", bus_address, 7'h15);
    $display("test registers done");
    wait_lock(0, 400);
    rd(8'h02);
    chk("status", v[4:0], 5'b00001);
    repeat (400) @(posedge mclk) #1;
    chk("raw word", raw_word, 5'h1f);
    chk("loopthrough a", loopthrough_out, 1);
    e0 = edge_count;
    repeat (1600) @(posedge mclk) #1;
    full = edge_count - e0;
    wr(8'h28, 8'h08);
    rd(8'h28);
    chk("timing reg", v, 8'h08);
    e0 = edge_count;
    repeat (1600) @(posedge mclk) #1;
    chk("half rate", (edge_count - e0) * 4 < full * 3, 1);
    wr(8'h28, 8'h00);
    $display("test raw lanes done");
    serial_input_select = 1'b1;
    repeat (400) @(posedge mclk) #1;
    chk("lock kept", lock_n, 0);
    chk("loopthrough b", loopthrough_out, 0);
    chk("raw word b", raw_word, 5'h00);
    cdr_phase_lost = 1'b1;
    serial_input_select = 1'b0;
    wait_lock(1, 100);
    cdr_phase_lost = 1'b0;
    wait_lock(0, 300);
    chk("relock short", n < 150, 1);
    serial_rate_b = 2'h1;
    serial_input_select = 1'b1;
    wait_lock(1, 100);
    wait_lock(0, 400);
    chk("relock long", n > 150, 1);
    $display("test input switch done");
    serial_rate_b = 2'h0;
    serial_input_select = 1'b0;
    wr(8'h27, 8'h01);
    stream_mode_sel = 1'b1;
    // A comma followed by one balanced data symbol that decodes to 8'hb5.
    pat = {sdd_pkg::COMMA_NEG, 10'h2aa};
    device_reset_n = 1'b0;
    repeat (6) @(posedge mclk) #1;
    chk("pin reset swing", output_swing_large, 0);
    chk("pin reset lock", lock_n, 1);
    chk("pin reset addr", bus_address, 7'h2d);
    device_reset_n = 1'b1;
    wait_lock(0, 400);
    repeat (800) @(posedge mclk) #1;
    wait_idle(0, 400);
    chk("data byte", byte_word, 8'hb5);
    wait_idle(1, 400);
    chk("idle byte", byte_word, sdd_pkg::IDLE_BYTE);
    chk("idle flag", byte_idle, 1);
    rd(8'h02);
    chk("status", v[4:0], 5'b01101);
    $display("test stream done");
    report_and_stop();
  end
endmodule

// File: hw/sdd_dec8b10b.sv
// Combinational 8b10b symbol decoder with idle comma detection.
`timescale 1ns/1ns
module sdd_dec8b10b (
  // Symbol in, first bit received in bit 9
  input wire logic [9:0] sym,
  // Decoded result
  output logic [7:0] data,
  output logic is_idle,
  output logic err
);
  localparam logic [5:0] T6 [32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17, 6'h1b, 6'h23, 6'h13, 6'h32,
    6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] T4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
  logic [5:0] d6;
  logic [3:0] d4;
  logic k28;

  // Either disparity form matches; balanced codes other than D.7 (6'h38) have only one form.
  function automatic logic [5:0] dec6(input logic [5:0] c);
    logic [5:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      if (c == T6[i] || (($countones(T6[i]) != 3 || i == 7) && c == ~T6[i])) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] dec4(input logic [3:0] c);
    logic [3:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      if (c == T4[i] || ((i == 0 || i == 3 || i == 4 || i == 7) && c == ~T4[i])) begin
        r = {1'b1, 3'(i)};
      end
    end
    if (c == 4'h7 || c == 4'h8) begin
      r = 4'hf;
    end
    return r;
  endfunction

  always_comb begin
    d6 = dec6(sym[9:4]);
    d4 = dec4(sym[3:0]);
    k28 = (sym[9:4] == sdd_pkg::K28_6B_NEG) || (sym[9:4] == sdd_pkg::K28_6B_POS);
    if (k28) begin
      is_idle = (sym[3:0] == sdd_pkg::K28_5_4B_NEG) || (sym[3:0] == sdd_pkg::K28_5_4B_POS);
      data = sdd_pkg::IDLE_BYTE;
      err = !is_idle;
    end else begin
      is_idle = 1'b0;
      data = {d4[2:0], d6[4:0]};
      err = !(d6[5] && d4[3]);
    end
  end
endmodule

// File: hw/sdd_fifo.sv
// Flop-based word FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module sdd_fifo #(
  parameter int W = 5,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } sdd_fifo_st_t;
  sdd_fifo_st_t q, n;
  logic push, pop;

  assign in_ready = (q.cnt != (PW+1)'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data;
      n.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
    end
    n.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (flush) begin
      n.wp = '0;
      n.rp = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
endmodule

// File: hw/sdd_pkg.sv
// Shared constants and types for the serial video deserializer output control block.
// What this block does
// RULE1: Power-up reset restores register defaults and starts acquisition on serial input a.
// RULE2: Reset pin low holds the device in reset; high resumes operation.
// RULE3: Writing the reset register restores defaults but keeps the bus address.
// RULE4: Output swing defaults small; the swing register selects the large swing.
// RULE5: Timing register sets clock-to-data skew and full or half rate clock.
// RULE6: Stream mode pin high enables framer and 8b10b decoder.
// RULE7: Stream mode puts one decoded nibble per clock edge on four lanes.
// RULE8: Stream mode drives the fifth lane high for idle character nibbles.
// RULE9: Stream mode sends the high nibble on rising, low on falling edge.
// RULE10: Select pin picks the input; its reclocked bits drive the loopthrough output.
// RULE11: Same-rate input switch normally keeps lock while the phase realigns.
// RULE12: Lost lock after a switch shows on lock_n, regained after 5 ms.
// RULE13: Different-rate switch runs the longer full acquisition.
// RULE14: Host re-establishes word framing after any input switch.
// RULE15: Host assembles five-bit lane words into 10 or 20 bit words.
// RULE16: Lock is reached within 24 ms after reset or rate change.
// RULE17: Outside stream mode raw recovered bits go out five per clock edge.
package sdd_pkg;
  // Register offsets.
  localparam logic [7:0] REG_BUS_ADDR = 8'h00;
  localparam logic [7:0] REG_SOFT_RESET = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_SWING = 8'h27;
  localparam logic [7:0] REG_TIMING = 8'h28;
  // Reset values; the bus address default is arbitrary.
  localparam logic [6:0] BUS_ADDR_RESET = 7'h2d;
  localparam logic [7:0] SWING_RESET = 8'h00;
  localparam logic [7:0] TIMING_RESET = 8'h00;
  // Field positions.
  localparam int SWING_LARGE_BIT = 0;
  localparam int TIMING_SKEW_LSB = 0;
  localparam int TIMING_SKEW_W = 3;
  localparam int TIMING_HALF_BIT = 3;
  localparam int ST_LOCKED = 0;
  localparam int ST_SEL = 1;
  localparam int ST_STREAM = 2;
  localparam int ST_FRAMED = 3;
  localparam int ST_OVF = 4;
  // Pin synchroniser lanes.
  localparam int RATE_W = 2;
  localparam int SY_RSTN = 0;
  localparam int SY_STREAM = 1;
  localparam int SY_SEL = 2;
  localparam int SY_LOST = 3;
  localparam int SY_BCLK = 4;
  localparam int SY_DA = 5;
  localparam int SY_DB = 6;
  localparam int SY_RATE_A = 7;
  localparam int SY_RATE_B = 9;
  localparam int SYNC_W = 11;
  // Timing.
  localparam longint CLK_FREQ_HZ = 100000000;
  localparam longint ACQ_TIME_MS = 24;
  localparam longint RELOCK_TIME_MS = 5;
  localparam longint REALIGN_TIME_NS = 640;
  localparam int unsigned ACQ_CYCLES = int'(ACQ_TIME_MS * CLK_FREQ_HZ / 1000);
  localparam int unsigned RELOCK_CYCLES = int'(RELOCK_TIME_MS * CLK_FREQ_HZ / 1000);
  localparam int unsigned REALIGN_CYCLES = int'(REALIGN_TIME_NS * CLK_FREQ_HZ / 1000000000);
  typedef logic [21:0] sdd_cnt_t;
  // Lanes, symbols and the idle comma.
  localparam int LANE_W = 5;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] RAW_LAST = 4'h4;
  localparam logic [3:0] SYM_LAST = 4'h9;
  localparam logic [5:0] K28_6B_NEG = 6'h0f;
  localparam logic [5:0] K28_6B_POS = 6'h30;
  localparam logic [3:0] K28_5_4B_NEG = 4'ha;
  localparam logic [3:0] K28_5_4B_POS = 4'h5;
  localparam logic [9:0] COMMA_NEG = {K28_6B_NEG, K28_5_4B_NEG};
  localparam logic [9:0] COMMA_POS = {K28_6B_POS, K28_5_4B_POS};
  localparam logic [7:0] IDLE_BYTE = 8'hbc;
  typedef enum logic [1:0] {LK_ACQUIRE, LK_LOCKED, LK_REALIGN, LK_RELOCK} sdd_lock_t;
endpackage

// File: hw/sdd_top.sv
// Deserializer control: input select, lock tracking, framing, lane output and registers.
`timescale 1ns/1ns
module sdd_top #(
  parameter int unsigned ACQ_CYCLES = sdd_pkg::ACQ_CYCLES,
  parameter int unsigned RELOCK_CYCLES = sdd_pkg::RELOCK_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control pins
  input wire logic device_reset_n,
  input wire logic stream_mode_sel,
  input wire logic serial_input_select,
  input wire logic cdr_phase_lost,
  // Recovered serial link
  input wire logic serial_bit_clk,
  input wire logic serial_input_a,
  input wire logic serial_input_b,
  input wire logic [1:0] serial_rate_a,
  input wire logic [1:0] serial_rate_b,
  // Register port
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Lanes to the host
  output logic [3:0] decoded_nibble_lanes,
  output logic idle_char_flag_lane,
  output logic forwarded_output_clock,
  // Status and loopthrough
  output logic lock_n,
  output logic loopthrough_out,
  output logic output_swing_large,
  output logic [6:0] bus_address
);
  localparam sdd_pkg::sdd_cnt_t ACQ_LAST = sdd_pkg::sdd_cnt_t'(ACQ_CYCLES - 1);
  localparam sdd_pkg::sdd_cnt_t RELOCK_LAST = sdd_pkg::sdd_cnt_t'(RELOCK_CYCLES - 1);
  localparam sdd_pkg::sdd_cnt_t REALIGN_LAST = sdd_pkg::sdd_cnt_t'(sdd_pkg::REALIGN_CYCLES - 1);
  localparam int LW = sdd_pkg::LANE_W;

  typedef struct packed {
    logic [sdd_pkg::SYNC_W-1:0] s1;
    logic [sdd_pkg::SYNC_W-1:0] s2;
    logic bclk_prev;
    sdd_pkg::sdd_lock_t lk;
    sdd_pkg::sdd_cnt_t cnt;
    logic act_sel;
    logic lock_n;
    logic [6:0] bus_addr;
    logic [7:0] swing;
    logic [7:0] timing;
    logic [7:0] rdata;
    logic ovf;
    logic loop_out;
    logic [9:0] win;
    logic framed;
    logic [3:0] bcnt;
    logic sym_rdy;
    logic push_valid;
    logic [LW-1:0] push_data;
    logic lsn_pend;
    logic [LW-1:0] lsn_word;
    logic [LW-1:0] lanes;
    logic fclk;
    logic half_tog;
    logic [sdd_pkg::TIMING_SKEW_W-1:0] skew;
    logic wait_edge;
  } sdd_top_st_t;

  sdd_top_st_t q, n;
  logic [sdd_pkg::SYNC_W-1:0] sync_in, keep_s1, keep_s2;
  logic pin_ok, stream, sel, lost, bclk_edge, sel_bit, active, rate_differs;
  logic [7:0] dec_byte;
  logic dec_idle, dec_err;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [LW-1:0] fifo_out_data;

  function automatic logic is_comma(input logic [9:0] w);
    return (w == sdd_pkg::COMMA_NEG) || (w == sdd_pkg::COMMA_POS);
  endfunction

  assign sync_in = {serial_rate_b, serial_rate_a, serial_input_b, serial_input_a,
                    serial_bit_clk, cdr_phase_lost, serial_input_select, stream_mode_sel,
                    device_reset_n};
  assign pin_ok = q.s2[sdd_pkg::SY_RSTN];
  assign stream = q.s2[sdd_pkg::SY_STREAM];
  assign sel = q.s2[sdd_pkg::SY_SEL];
  assign lost = q.s2[sdd_pkg::SY_LOST];
  assign bclk_edge = q.s2[sdd_pkg::SY_BCLK] & ~q.bclk_prev;
  assign sel_bit = q.act_sel ? q.s2[sdd_pkg::SY_DB] : q.s2[sdd_pkg::SY_DA]; // RULE10
  assign active = (q.lk == sdd_pkg::LK_LOCKED) || (q.lk == sdd_pkg::LK_REALIGN);
  assign rate_differs = q.s2[sdd_pkg::SY_RATE_A +: sdd_pkg::RATE_W]
                        != q.s2[sdd_pkg::SY_RATE_B +: sdd_pkg::RATE_W];
  assign fifo_out_ready = !q.wait_edge;

  sdd_dec8b10b u_dec (
    .sym(q.win),
    .data(dec_byte),
    .is_idle(dec_idle),
    .err(dec_err)
  );

  sdd_fifo #(
    .W(LW),
    .DEPTH(sdd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(mclk),
    .rst_n(resetn),
    .flush(!pin_ok),
    .in_valid(q.push_valid),
    .in_ready(fifo_in_ready),
    .in_data(q.push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_comb begin
    n = q;
    keep_s1 = sync_in;
    keep_s2 = q.s1;
    n.s1 = keep_s1;
    n.s2 = keep_s2;
    n.bclk_prev = q.s2[sdd_pkg::SY_BCLK];

    ////////////////////////////////////////////////////////////////////////////////
    // Deserialiser: a decoded symbol goes out as high nibble, then low nibble.
    n.push_valid = 1'b0;
    n.sym_rdy = 1'b0;
    if (q.lsn_pend) begin
      n.push_valid = 1'b1; // RULE9
      n.push_data = q.lsn_word;
      n.lsn_pend = 1'b0;
    end else if (q.sym_rdy) begin
      if (dec_err) begin
        n.framed = 1'b0;
      end else begin
        n.push_valid = 1'b1; // RULE7
        n.push_data = {dec_idle, dec_byte[7:4]}; // RULE8
        n.lsn_pend = 1'b1;
        n.lsn_word = {dec_idle, dec_byte[3:0]};
      end
    end
    if (bclk_edge) begin
      n.loop_out = sel_bit; // RULE10
      if (active) begin
        n.win = {q.win[8:0], sel_bit};
        if (stream) begin
          if (!q.framed) begin
            if (is_comma(n.win)) begin
              n.framed = 1'b1; // RULE6
              n.bcnt = '0;
              n.sym_rdy = 1'b1;
            end
          end else if (q.bcnt == sdd_pkg::SYM_LAST) begin
            n.bcnt = '0;
            n.sym_rdy = 1'b1;
          end else begin
            n.bcnt = q.bcnt + 1'b1;
          end
        end else if (q.bcnt >= sdd_pkg::RAW_LAST) begin
          n.bcnt = '0;
          n.push_valid = 1'b1; // RULE17
          n.push_data = n.win[LW-1:0];
        end else begin
          n.bcnt = q.bcnt + 1'b1;
        end
      end
    end
    if (!stream) begin
      n.framed = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Lock tracking and input switching.
    n.cnt = q.cnt + 1'b1;
    unique case (q.lk)
      sdd_pkg::LK_ACQUIRE: begin
        if (q.cnt == ACQ_LAST) begin
          n.lk = sdd_pkg::LK_LOCKED; // RULE16
          n.cnt = '0;
        end
      end
      sdd_pkg::LK_LOCKED: begin
        n.cnt = '0;
        if (sel != q.act_sel) begin
          n.act_sel = sel;
          n.framed = 1'b0;
          n.lsn_pend = 1'b0;
          // Words framed on the old source are meaningless on the new one.
          n.lk = rate_differs ? sdd_pkg::LK_ACQUIRE : sdd_pkg::LK_REALIGN; // RULE11 RULE13
        end
      end
      sdd_pkg::LK_REALIGN: begin
        if (lost) begin
          n.lk = sdd_pkg::LK_RELOCK; // RULE12
          n.cnt = '0;
        end else if (q.cnt == REALIGN_LAST) begin
          n.lk = sdd_pkg::LK_LOCKED;
          n.cnt = '0;
        end
      end
      sdd_pkg::LK_RELOCK: begin
        if (q.cnt == RELOCK_LAST) begin
          n.lk = sdd_pkg::LK_LOCKED; // RULE12
          n.cnt = '0;
        end
      end
    endcase
    n.lock_n = !((n.lk == sdd_pkg::LK_LOCKED) || (n.lk == sdd_pkg::LK_REALIGN));

    ////////////////////////////////////////////////////////////////////////////////
    // Lane driver: data changes, then the clock edge follows after the skew.
    if (!q.wait_edge && fifo_out_valid) begin
      n.lanes = fifo_out_data;
      n.skew = q.timing[sdd_pkg::TIMING_SKEW_LSB +: sdd_pkg::TIMING_SKEW_W]; // RULE5
      n.wait_edge = 1'b1;
    end else if (q.wait_edge) begin
      if (q.skew == '0) begin
        n.wait_edge = 1'b0;
        n.half_tog = ~q.half_tog;
        if (!q.timing[sdd_pkg::TIMING_HALF_BIT] || q.half_tog) begin
          n.fclk = ~q.fclk; // RULE5 RULE9
        end
      end else begin
        n.skew = q.skew - 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.
    case (reg_addr)
      sdd_pkg::REG_BUS_ADDR: n.rdata = {1'b0, q.bus_addr};
      sdd_pkg::REG_SWING: n.rdata = q.swing;
      sdd_pkg::REG_TIMING: n.rdata = q.timing;
      sdd_pkg::REG_STATUS: begin
        n.rdata = '0;
        n.rdata[sdd_pkg::ST_LOCKED] = !q.lock_n;
        n.rdata[sdd_pkg::ST_SEL] = q.act_sel;
        n.rdata[sdd_pkg::ST_STREAM] = stream;
        n.rdata[sdd_pkg::ST_FRAMED] = q.framed;
        n.rdata[sdd_pkg::ST_OVF] = q.ovf;
      end
      default: n.rdata = '0;
    endcase
    if (reg_wr) begin
      case (reg_addr)
        sdd_pkg::REG_BUS_ADDR: n.bus_addr = reg_wdata[6:0];
        sdd_pkg::REG_SWING: n.swing = reg_wdata; // RULE4
        sdd_pkg::REG_TIMING: n.timing = reg_wdata;
        sdd_pkg::REG_SOFT_RESET: begin
          n.swing = sdd_pkg::SWING_RESET; // RULE3
          n.timing = sdd_pkg::TIMING_RESET;
          n.ovf = 1'b0;
        end
        default: n.ovf = n.ovf;
      endcase
    end
    // The host cannot stall the serial line, so a refused word is counted as lost.
    if (q.push_valid && !fifo_in_ready) begin
      n.ovf = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reset pin: everything but the synchronisers returns to its power-up value.
    if (!pin_ok) begin
      n = '0; // RULE2
      n.s1 = keep_s1;
      n.s2 = keep_s2;
      n.bus_addr = sdd_pkg::BUS_ADDR_RESET;
      n.swing = sdd_pkg::SWING_RESET;
      n.timing = sdd_pkg::TIMING_RESET;
      n.lock_n = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q <= '0; // RULE1
      q.bus_addr <= sdd_pkg::BUS_ADDR_RESET;
      q.swing <= sdd_pkg::SWING_RESET;
      q.timing <= sdd_pkg::TIMING_RESET;
      q.lock_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign decoded_nibble_lanes = q.lanes[3:0];
  assign idle_char_flag_lane = q.lanes[LW-1];
  assign forwarded_output_clock = q.fclk;
  assign lock_n = q.lock_n;
  assign loopthrough_out = q.loop_out;
  assign output_swing_large = q.swing[sdd_pkg::SWING_LARGE_BIT];
  assign bus_address = q.bus_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  soft_reset_regs_a: assert property ( // RULE3
    reg_wr && reg_addr == sdd_pkg::REG_SOFT_RESET && pin_ok |=>
      q.swing == sdd_pkg::SWING_RESET && q.timing == sdd_pkg::TIMING_RESET
      && bus_address == $past(bus_address))
    else $error("soft reset did not restore registers or lost the address");
  swing_select_a: assert property ( // RULE4
    reg_wr && reg_addr == sdd_pkg::REG_SWING && pin_ok |=>
      output_swing_large == $past(reg_wdata[sdd_pkg::SWING_LARGE_BIT]))
    else $error("swing output does not follow the swing register");
  pin_reset_a: assert property ( // RULE2
    !pin_ok |=> lock_n && q.lk == sdd_pkg::LK_ACQUIRE && !q.act_sel && !output_swing_large)
    else $error("reset pin did not restore defaults");
  acquire_bound_a: assert property ( // RULE16
    q.lk == sdd_pkg::LK_ACQUIRE |-> q.cnt <= ACQ_LAST && lock_n)
    else $error("acquisition exceeds its time bound");
  rate_switch_a: assert property ( // RULE13
    q.lk == sdd_pkg::LK_LOCKED && sel != q.act_sel && rate_differs && pin_ok |=>
      q.lk == sdd_pkg::LK_ACQUIRE && lock_n && q.cnt == '0)
    else $error("different rate switch did not restart acquisition");
  same_rate_a: assert property ( // RULE11
    q.lk == sdd_pkg::LK_LOCKED && sel != q.act_sel && !rate_differs && pin_ok |=>
      q.lk == sdd_pkg::LK_REALIGN && !lock_n && q.act_sel == $past(sel))
    else $error("same rate switch dropped lock");
  relock_pulse_a: assert property ( // RULE12
    q.lk == sdd_pkg::LK_REALIGN && lost && pin_ok |=> lock_n && q.lk == sdd_pkg::LK_RELOCK)
    else $error("lost lock not shown on lock_n");
  relock_end_a: assert property ( // RULE12
    q.lk == sdd_pkg::LK_RELOCK && q.cnt == RELOCK_LAST && pin_ok |=> !lock_n)
    else $error("lock not regained at end of relock time");
  loop_thru_a: assert property ( // RULE10
    bclk_edge && pin_ok |=> loopthrough_out == $past(sel_bit))
    else $error("loopthrough does not carry the selected input");
  nibble_order_a: assert property ( // RULE9
    q.sym_rdy && !dec_err && stream && pin_ok |=>
      q.push_valid && q.push_data == {$past(dec_idle), $past(dec_byte[7:4])}
      ##1 q.push_valid && q.push_data == {$past(dec_idle, 2), $past(dec_byte[3:0], 2)})
    else $error("nibbles or idle flag pushed in wrong order");
  comma_frame_a: assert property ( // RULE6
    bclk_edge && active && stream && !q.framed && is_comma({q.win[8:0], sel_bit}) && pin_ok
      |=> q.framed && q.sym_rdy)
    else $error("framer missed the comma");
  raw_word_a: assert property ( // RULE17
    bclk_edge && active && !stream && q.bcnt >= sdd_pkg::RAW_LAST && pin_ok |=>
      q.push_valid && q.push_data[0] == $past(sel_bit))
    else $error("raw five bit word not pushed");
  full_rate_edge_a: assert property ( // RULE5
    q.wait_edge && q.skew == '0 && !q.timing[sdd_pkg::TIMING_HALF_BIT] && pin_ok |=>
      forwarded_output_clock != $past(forwarded_output_clock))
    else $error("forwarded clock missed an edge at full rate");
endmodule
